/* File: design/charge_cycle_controller.sv */
/*
 Supervisory state machine of a stand-alone switch-mode charger: decides
 when charging runs, in which phase, with what current target.
 Assumes comparator flags arrive asynchronously and the fast-charge timeout
 in clock cycles is supplied already converted from the program capacitor.
*/
module charge_cycle_controller
   import charge_cycle_pkg::*;
#(
   parameter longint PRECHG_LIMIT  = PRECHG_CYC,
   parameter longint POWERUP_LIMIT = POWERUP_CYC,
   parameter longint DEGLITCH_LIM  = DEGLITCH_CYC,
   parameter longint SS_STEP_LIM   = SS_STEP_CYC
)(
   // Clock and reset
   input  wire logic             sys_clk_i,
   input  wire logic             rst_i,
   input  wire logic             clk_en_i,
   // Analog comparator flags
   input  wire flags_type        flags_i,
   // Fast-charge timer programming and current setpoint
   input  wire timer_mode_type   timer_mode_i,
   input  wire logic [CNT_W-1:0] fast_timeout_cyc_i,
   input  wire logic [TGT_W-1:0] setpoint_code_i,
   // Charge control
   output logic                  charge_en_o,
   output logic                  precharge_o,
   output logic [TGT_W-1:0]      current_target_o,
   output logic                  input_fet_en_o,
   // Reference and status
   output logic                  ref_en_o,
   output logic                  sleep_o,
   output logic                  stat_out_o,
   output logic                  stat_oe_n_o,
   output logic                  fault_o,
   output logic                  done_o
);

   // ----------------------------------------------------------------
   // Synchronised flags
   // ----------------------------------------------------------------
   flags_type flg;
   logic [FLAGS_W-1:0] flg_vec;

   flag_sync #(
      .WIDTH (FLAGS_W)
   ) u_sync (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .clk_en_i  (clk_en_i),
      .async_i   (flags_i),
      .sync_o    (flg_vec)
   );
   assign flg = flags_type'(flg_vec);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   charge_state_type  state_ff, nxt_state;
   logic              setpoint_en_ff;
   logic              sleep_ff;
   logic              toggle_seen_ff;
   logic              por_pending_ff;
   logic [CNT_W-1:0]  pwr_cnt_ff;
   logic              pwr_done_ff;
   logic [CNT_W-1:0]  safety_cnt_ff;
   logic [CNT_W-1:0]  ss_cnt_ff;
   logic [3:0]        ss_step_ff;
   logic              recharge_prev_ff;
   logic              charge_en_ff;
   logic              precharge_ff;
   logic [TGT_W-1:0]  target_ff;
   logic              fet_en_ff;
   logic              stat_oe_n_ff;
   logic              stat_out_ff;
   logic              fault_ff;
   logic              done_ff;

   // ----------------------------------------------------------------
   // Setpoint hysteresis and toggle detect
   // ----------------------------------------------------------------
   wire nxt_setpoint_en = flg.setpoint_above_high ? 1'b1 :
                          flg.setpoint_below_low  ? 1'b0 : setpoint_en_ff;
   wire setpoint_rise   = nxt_setpoint_en && !setpoint_en_ff;

   // Enable conditions
   wire adapter_ok = !flg.adapter_overvoltage && !flg.adapter_undervoltage;
   wire nxt_sleep  = flg.supply_above_sense ? 1'b0 :
                     flg.sense_above_supply ? 1'b1 : sleep_ff;
   wire enable_ok  = setpoint_en_ff && !flg.supply_uvlo && !nxt_sleep &&
                     adapter_ok && pwr_done_ff && flg.ldo_good &&
                     !flg.thermal_shutdown && !flg.temp_fault &&
                     flg.adapter_path_fet;

   // New cycle triggers
   wire recharge_fall = flg.below_recharge && !recharge_prev_ff;
   wire setpoint_trig = setpoint_rise && toggle_seen_ff;
   wire new_cycle     = recharge_fall || setpoint_trig || por_pending_ff;

   // Phase selection with persistence filter
   logic low_batt_filt;
   deglitch_timer #(
      .LIMIT (DEGLITCH_LIM)
   ) u_phase (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .clk_en_i  (clk_en_i),
      .load_i    (new_cycle),
      .level_i   (flg.below_low_battery),
      .filt_o    (low_batt_filt)
   );

   // Timer modes
   wire timer_on = (timer_mode_i == TIMER_PROG_CAP);
   wire term_on  = (timer_mode_i != TIMER_PROG_GND);

   wire prechg_expired = (safety_cnt_ff >= CNT_W'(PRECHG_LIMIT - 1));
   wire fast_expired   = timer_on &&
                         (safety_cnt_ff >= fast_timeout_cyc_i);
   wire terminate      = term_on && flg.in_voltage_reg &&
                         !flg.below_recharge && flg.current_below_term;

   // ----------------------------------------------------------------
   // State decode
   // ----------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_OFF: begin
            if (enable_ok)
               nxt_state = low_batt_filt ? ST_PRECHARGE : ST_FAST;
         end
         ST_PRECHARGE: begin
            if (!enable_ok)
               nxt_state = ST_OFF;
            else if (prechg_expired)
               nxt_state = ST_FAULT;
            else if (!low_batt_filt)
               nxt_state = ST_FAST;
         end
         ST_FAST: begin
            if (!enable_ok)
               nxt_state = ST_OFF;
            else if (fast_expired)
               nxt_state = ST_FAULT;
            else if (low_batt_filt)
               nxt_state = ST_PRECHARGE;
            else if (terminate)
               nxt_state = ST_DONE;
         end
         ST_DONE: begin
            if (new_cycle)
               nxt_state = ST_OFF;
         end
         ST_FAULT: begin
            if (new_cycle)
               nxt_state = ST_OFF;
         end
         default: nxt_state = ST_OFF;
      endcase
      if (flg.supply_uvlo)
         nxt_state = ST_OFF;
   end

   wire charging   = (nxt_state == ST_PRECHARGE) || (nxt_state == ST_FAST);
   wire phase_chg  = (nxt_state != state_ff);
   wire fast_entry = (nxt_state == ST_FAST) && phase_chg;
   wire ss_tick    = (ss_cnt_ff >= CNT_W'(SS_STEP_LIM - 1));
   wire [3:0] nxt_ss_step = fast_entry ? 4'h1 :
                            (ss_tick && ss_step_ff < SS_STEP_LAST) ?
                            ss_step_ff + 4'h1 : ss_step_ff;
   wire [TGT_W+3:0] ramp_prod = setpoint_code_i * nxt_ss_step;
   wire [TGT_W-1:0] ramp_tgt  = TGT_W'(ramp_prod / SS_STEPS);
   wire [TGT_W-1:0] pre_tgt   = TGT_W'(setpoint_code_i / PRECHG_DIV);
   wire [TGT_W-1:0] nxt_target =
        (nxt_state == ST_FAST)      ? ramp_tgt :
        (nxt_state == ST_PRECHARGE) ? pre_tgt  : '0;
   wire nxt_fet_en = adapter_ok && !flg.supply_uvlo && !nxt_sleep;

   // ----------------------------------------------------------------
   // Condition tracking
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         setpoint_en_ff   <= 1'b0;
         sleep_ff         <= 1'b1;
         toggle_seen_ff   <= 1'b0;
         por_pending_ff   <= 1'b1;
         recharge_prev_ff <= 1'b0;
      end else if (clk_en_i) begin
         setpoint_en_ff   <= nxt_setpoint_en;
         sleep_ff         <= nxt_sleep;
         recharge_prev_ff <= flg.below_recharge;
         por_pending_ff   <= 1'b0;
         // Remember a disable so the following enable counts as a toggle
         if (setpoint_rise)
            toggle_seen_ff <= 1'b0;
         else if (!nxt_setpoint_en && setpoint_en_ff)
            toggle_seen_ff <= 1'b1;
      end
   end

   // Power-up delay after setpoint enable
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pwr_cnt_ff  <= '0;
         pwr_done_ff <= 1'b0;
      end else if (clk_en_i) begin
         if (flg.supply_uvlo || !setpoint_en_ff) begin
            pwr_cnt_ff  <= '0;
            pwr_done_ff <= 1'b0;
         end else if (pwr_cnt_ff >= CNT_W'(POWERUP_LIMIT - 1)) begin
            pwr_done_ff <= 1'b1;
         end else begin
            pwr_cnt_ff  <= pwr_cnt_ff + CNT_W'(1);
         end
      end
   end

   // Safety timer and soft-start step counter
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         safety_cnt_ff <= '0;
         ss_cnt_ff     <= '0;
         ss_step_ff    <= '0;
      end else if (clk_en_i) begin
         if (!charging || phase_chg ||
             (state_ff == ST_FAST && !timer_on))
            safety_cnt_ff <= '0;
         else
            safety_cnt_ff <= safety_cnt_ff + CNT_W'(1);
         ss_cnt_ff  <= (fast_entry || ss_tick) ? '0 : ss_cnt_ff + CNT_W'(1);
         ss_step_ff <= nxt_ss_step;
      end
   end

   // State and registered outputs
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_ff     <= ST_OFF;
         charge_en_ff <= 1'b0;
         precharge_ff <= 1'b0;
         target_ff    <= '0;
         fet_en_ff    <= 1'b0;
         stat_oe_n_ff <= 1'b1;
         stat_out_ff  <= 1'b0;
         fault_ff     <= 1'b0;
         done_ff      <= 1'b0;
      end else if (clk_en_i) begin
         state_ff     <= nxt_state;
         charge_en_ff <= charging;
         precharge_ff <= (nxt_state == ST_PRECHARGE);
         target_ff    <= nxt_target;
         fet_en_ff    <= nxt_fet_en;
         stat_oe_n_ff <= nxt_sleep || flg.supply_uvlo ||
                         !(charging || nxt_state == ST_FAULT);
         stat_out_ff  <= 1'b0;                                               // Open-drain pull
         fault_ff     <= (nxt_state == ST_FAULT);
         done_ff      <= (nxt_state == ST_DONE);
      end
   end

   assign charge_en_o      = charge_en_ff;
   assign precharge_o      = precharge_ff;
   assign current_target_o = target_ff;
   assign input_fet_en_o   = fet_en_ff;
   assign ref_en_o         = !sleep_ff;   // Driven by flop
   assign sleep_o          = sleep_ff;
   assign stat_out_o       = stat_out_ff;
   assign stat_oe_n_o      = stat_oe_n_ff;
   assign fault_o          = fault_ff;
   assign done_o           = done_ff;

endmodule // charge_cycle_controller

/* File: design/charge_cycle_pkg.sv */
/*
 Constants, state type and carrier structs for the charge-cycle supervisor.
 Assumes a 100 MHz system clock; long counts are overridable at the top.
*/
package charge_cycle_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int  CLK_HZ           = 100_000_000;
   localparam int  DEGLITCH_MS      = 25;
   localparam int  POWERUP_DELAY_MS = 1500;
   localparam int  SS_STEP_US       = 1600;
   localparam int  PRECHG_MIN       = 30;
   localparam longint DEGLITCH_CYC  = longint'(CLK_HZ) / 1000 * DEGLITCH_MS;
   localparam longint POWERUP_CYC   = longint'(CLK_HZ) / 1000 * POWERUP_DELAY_MS;
   localparam longint SS_STEP_CYC   = longint'(CLK_HZ) / 1000 * SS_STEP_US / 1000;
   localparam longint PRECHG_CYC    = longint'(CLK_HZ) * 60 * PRECHG_MIN;
   localparam int  CNT_W            = 40;

   // ----------------------------------------------------------------
   // Current target
   // ----------------------------------------------------------------
   localparam int        TGT_W         = 8;
   localparam int        SS_STEPS      = 8;
   localparam int        PRECHG_DIV    = 10;
   localparam logic [3:0] SS_STEP_LAST = 4'h8;

   // ----------------------------------------------------------------
   // Timer program pin decode
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      TIMER_PROG_CAP   = 2'h0,   // Capacitor: timer and termination on
      TIMER_PROG_GND   = 2'h1,   // Pin to analog_ground: both off
      TIMER_PROG_REF   = 2'h2    // Pin to reference: timer off only
   } timer_mode_type;

   typedef enum {
      ST_OFF,
      ST_PRECHARGE,
      ST_FAST,
      ST_DONE,
      ST_FAULT
   } charge_state_type;

   // Comparator flags from the analog front end
   typedef struct packed {
      logic setpoint_below_low;   // charge_setpoint_pin < 40 mV
      logic setpoint_above_high;  // charge_setpoint_pin > 120 mV
      logic supply_uvlo;          // chip_supply below lockout
      logic supply_above_sense;   // chip_supply > battery_sense_node
      logic sense_above_supply;   // battery_sense_node > chip_supply
      logic adapter_overvoltage;  // adapter_qualify_input > 1.6 V
      logic adapter_undervoltage; // adapter_qualify_input < 0.5 V
      logic ldo_good;             // gate_drive_ldo and reference good
      logic thermal_shutdown;
      logic temp_fault;           // battery_temp_sense out of range
      logic adapter_path_fet;     // Path FET reported on
      logic below_low_battery;    // Battery under low_battery_threshold
      logic below_recharge;       // voltage_feedback under recharge level
      logic current_below_term;   // Charge current under termination
      logic in_voltage_reg;       // Voltage regulation loop active
   } flags_type;

   localparam int FLAGS_W = $bits(flags_type);

endpackage

/* File: design/deglitch_timer.sv */
/*
 Persistence filter: the output follows the input after the input has
 held its new value for LIMIT consecutive enabled cycles, or at once on load_i.
 Assumes a synchronous input.
*/
module deglitch_timer
   import charge_cycle_pkg::*;
#(
   parameter longint LIMIT = DEGLITCH_CYC
)(
   // Clock and reset
   input  wire logic sys_clk_i,
   input  wire logic rst_i,
   input  wire logic clk_en_i,
   // Filter
   input  wire logic load_i,     // Force output to level_i at once
   input  wire logic level_i,
   output logic      filt_o
);

   logic [CNT_W-1:0] cnt_ff;
   logic             filt_ff;

   wire differs  = (level_i != filt_ff);
   wire cnt_done = (cnt_ff >= CNT_W'(LIMIT - 1));

   // Count while input differs from output; restart on agreement
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_ff  <= '0;
         filt_ff <= 1'b0;
      end else if (clk_en_i) begin
         if (load_i || (differs && cnt_done)) begin
            filt_ff <= level_i;
            cnt_ff  <= '0;
         end else if (differs) begin
            cnt_ff  <= cnt_ff + CNT_W'(1);
         end else begin
            cnt_ff  <= '0;
         end
      end
   end

   assign filt_o = filt_ff;

endmodule // deglitch_timer

/* File: design/flag_sync.sv */
/*
 Two-flop synchroniser for a vector of asynchronous comparator flags.
 Assumes flags may change at any time relative to sys_clk_i.
*/
module flag_sync
   import charge_cycle_pkg::*;
#(
   parameter int WIDTH = 1
)(
   // Clock and reset
   input  wire logic             sys_clk_i,
   input  wire logic             rst_i,
   input  wire logic             clk_en_i,
   // Flags
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   // ----------------------------------------------------------------
   // Per-bit two-stage chain
   // ----------------------------------------------------------------
   for (genvar b = 0; b < WIDTH; b++) begin : g_bit
      always_ff @(posedge sys_clk_i or posedge rst_i) begin
         if (rst_i) begin
            meta_ff[b] <= 1'b0;
            sync_ff[b] <= 1'b0;
         end else if (clk_en_i) begin
            meta_ff[b] <= async_i[b];
            sync_ff[b] <= meta_ff[b];
         end
      end
   end

   assign sync_o = sync_ff;

endmodule // flag_sync

/* File: verification/battery_pack_model.sv */
/*
 Adapter and battery pack model: passes the adapter-side levels from the
 bench and derives the battery levels from a stored charge level.
 Assumes the level grows by the current target each clock while charging.
*/
module battery_pack_model
   import charge_cycle_pkg::*;
#(
   parameter int LOW_LVL  = 600,
   parameter int RECH_LVL = 18000,
   parameter int FULL_LVL = 20000
)(
   // Clock
   input  wire logic             sys_clk_i,
   // Bench command and charger drive
   input  wire logic [1:0]       cmd_i,
   input  wire flags_type        env_i,
   input  wire logic             charge_en_i,
   input  wire logic [TGT_W-1:0] target_i,
   // Comparator levels
   output flags_type             flags_o
);
   int level_ff = 0;

   // Charge, hold, drop just under recharge, or dead cell
   always @(posedge sys_clk_i) begin
      case (cmd_i)
         2'h0: if (charge_en_i) level_ff <= (level_ff + int'(target_i) > FULL_LVL) ?
                  FULL_LVL : level_ff + int'(target_i);
         2'h2: level_ff <= RECH_LVL - 1;
         2'h3: level_ff <= 0;
         default: ;
      endcase
   end

   // Battery levels merged with the adapter-side ones
   always_comb begin
      flags_o = env_i;
      flags_o.below_low_battery  = level_ff < LOW_LVL;
      flags_o.below_recharge     = level_ff < RECH_LVL;
      flags_o.in_voltage_reg     = level_ff >= FULL_LVL;
      flags_o.current_below_term = level_ff >= FULL_LVL;
   end
endmodule // battery_pack_model

/* File: verification/charge_cycle_checker.sv */
/*
 Concurrent checks on the charge-cycle supervisor, bound to its top module.
 Assumes one clock, an asynchronous reset and the shortened counts.
*/
module charge_cycle_checker
   import charge_cycle_pkg::*;
#(
   parameter longint PRECHG_LIMIT = PRECHG_CYC,
   parameter longint DEGLITCH_LIM = DEGLITCH_CYC
)(
   // Clock, reset and inputs
   input wire logic             sys_clk_i,
   input wire logic             rst_i,
   input wire flags_type        flags_i,
   input wire timer_mode_type   timer_mode_i,
   input wire logic [TGT_W-1:0] setpoint_code_i,
   // Design outputs
   input wire logic             charge_en_o,
   input wire logic             precharge_o,
   input wire logic [TGT_W-1:0] current_target_o,
   input wire logic             input_fet_en_o,
   input wire logic             ref_en_o,
   input wire logic             sleep_o,
   input wire logic             stat_out_o,
   input wire logic             stat_oe_n_o,
   input wire logic             fault_o,
   input wire logic             done_o
);
   // ------------
   // Helpers
   // ------------
   logic [7:0]  lo_cnt_ff;
   logic [15:0] pre_cnt_ff;
   logic [7:0]  fast_cnt_ff;
   wire         fast_w = charge_en_o && !precharge_o;

   // Run lengths of battery above low level, pre-charge and fast charge
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         lo_cnt_ff   <= 8'h00;
         pre_cnt_ff  <= 16'h0000;
         fast_cnt_ff <= 8'h00;
      end else begin
         lo_cnt_ff   <= flags_i.below_low_battery ? 8'h00 : lo_cnt_ff + {7'h00, lo_cnt_ff != 8'hFF};
         pre_cnt_ff  <= precharge_o ? pre_cnt_ff + 16'h0001 : 16'h0000;
         fast_cnt_ff <= fast_w ? fast_cnt_ff + {7'h00, fast_cnt_ff != 8'hFF} : 8'h00;
      end
   end

   // ------------
   // Properties
   // ------------
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   // A flag held past the synchroniser and one state update
   sequence held(s);
      s [*4];
   endsequence
   sequence fast_entry;
      $rose(fast_w);
   endsequence

   a_sleep_ref: assert property (ref_en_o != sleep_o)
      else $error("reference enable does not follow sleep");
   a_sleep_quiet: assert property (sleep_o |-> stat_oe_n_o && !charge_en_o && !input_fet_en_o)
      else $error("activity while asleep");
   a_stat_drive: assert property ((charge_en_o || fault_o) |-> !stat_oe_n_o && !stat_out_o)
      else $error("status not pulled while charging or faulted");
   a_sleep_enter: assert property (held(flags_i.sense_above_supply) |=> sleep_o)
      else $error("sleep not entered");
   a_uvlo_off: assert property (held(flags_i.supply_uvlo) |=> !charge_en_o && !input_fet_en_o)
      else $error("activity under lockout");
   a_adapter_off: assert property (held(flags_i.adapter_overvoltage || flags_i.adapter_undervoltage)
      |=> !input_fet_en_o && !charge_en_o)
      else $error("adapter outside window but path on");
   a_loss_stop: assert property (held(!flags_i.ldo_good || flags_i.thermal_shutdown
      || flags_i.temp_fault || !flags_i.adapter_path_fet || flags_i.setpoint_below_low)
      |=> !charge_en_o)
      else $error("charging with an enable condition lost");
   a_sync_lag: assert property ($rose(flags_i.adapter_overvoltage) && input_fet_en_o
      |=> input_fet_en_o)
      else $error("flag acted without synchronisation");
   a_pre_target: assert property (precharge_o |-> charge_en_o
      && current_target_o == setpoint_code_i / 8'h0A)
      else $error("pre-charge target wrong");
   a_off_target: assert property (!charge_en_o |-> current_target_o == 8'h00)
      else $error("target not zero while off");
   a_fault_hold: assert property (fault_o |-> !charge_en_o && !done_o)
      else $error("charging while faulted");
   a_pre_timer: assert property (precharge_o |-> pre_cnt_ff <= PRECHG_LIMIT + 1)
      else $error("pre-charge outlived its timer");
   a_deglitch: assert property ($fell(precharge_o) && charge_en_o
      |-> lo_cnt_ff >= DEGLITCH_LIM)
      else $error("phase change without persistence");
   a_ss_start: assert property (fast_entry |-> current_target_o == setpoint_code_i >> 3)
      else $error("soft start first step wrong");
   a_ss_rise: assert property (fast_w && $past(fast_w)
      |-> current_target_o >= $past(current_target_o))
      else $error("soft start target fell");
   a_ss_full: assert property (fast_cnt_ff == 8'h46 |-> current_target_o == setpoint_code_i)
      else $error("soft start did not reach the setpoint");
   a_term_gate: assert property ($rose(done_o) |-> $past(timer_mode_i) != TIMER_PROG_GND
      && $past(flags_i.current_below_term) && !$past(flags_i.below_recharge))
      else $error("termination without its conditions");
endmodule // charge_cycle_checker

bind charge_cycle_controller charge_cycle_checker #(
   .PRECHG_LIMIT(PRECHG_LIMIT),
   .DEGLITCH_LIM(DEGLITCH_LIM)
) charge_cycle_checker_inst (
   .sys_clk_i, .rst_i, .flags_i, .timer_mode_i, .setpoint_code_i, .charge_en_o,
   .precharge_o, .current_target_o, .input_fet_en_o, .ref_en_o, .sleep_o,
   .stat_out_o, .stat_oe_n_o, .fault_o, .done_o
);

/* File: verification/tb_charge_cycle_controller.sv */
/*
 Self-checking bench for the charge-cycle supervisor with shortened counts.
 Assumes the battery model and the bound checker sit beside the design.
*/
module tb_charge_cycle_controller import charge_cycle_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;

   logic             sys_clk_i = 1'b0;
   logic             rst_i     = 1'b1;
   flags_type        env;
   flags_type        flags;
   timer_mode_type   mode      = TIMER_PROG_CAP;
   logic [CNT_W-1:0] tmo       = 40'hFF_FFFF_FFFF;
   logic [TGT_W-1:0] code, tgt;
   logic [1:0]       cmd       = 2'h0;
   logic             chg, pre, fet, refe, slp, sout, soe_n, flt, done;
   logic [13:0]      q[$];
   logic [13:0]      exp_v;
   logic [5:0]       prev      = 6'h20;
   bit               mute      = 1'b0;
   int               errors    = 0;
   int               checks_done = 0;
   int               cyc       = 0;
   wire  [5:0]       word      = {slp, fet, chg, pre, flt, done};

   always #5 sys_clk_i = ~sys_clk_i;

   charge_cycle_controller #(
      .PRECHG_LIMIT (200),
      .POWERUP_LIMIT(50),
      .DEGLITCH_LIM (10),
      .SS_STEP_LIM  (8)
   ) charge_cycle_controller_inst (
      .sys_clk_i         (sys_clk_i),
      .rst_i             (rst_i),
      .clk_en_i          (1'b1),
      .flags_i           (flags),
      .timer_mode_i      (mode),
      .fast_timeout_cyc_i(tmo),
      .setpoint_code_i   (code),
      .charge_en_o       (chg),
      .precharge_o       (pre),
      .current_target_o  (tgt),
      .input_fet_en_o    (fet),
      .ref_en_o          (refe),
      .sleep_o           (slp),
      .stat_out_o        (sout),
      .stat_oe_n_o       (soe_n),
      .fault_o           (flt),
      .done_o            (done)
   );

   battery_pack_model battery_pack_model_inst (
      .sys_clk_i  (sys_clk_i),
      .cmd_i      (cmd),
      .env_i      (env),
      .charge_en_i(chg),
      .target_i   (tgt),
      .flags_o    (flags)
   );

   // ------------
   // Tasks
   // ------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic note(input logic [5:0] st, input logic [7:0] t);
      q.push_back({st, t});
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask

   // Waits for every noted change, then lets the outputs rest
   task automatic settle(input int n);
      for (int i = 0; i < n && q.size() != 0; i++) @(posedge sys_clk_i);
      check("pending", 16'(q.size()), 16'h0000);
      idle(3);
   endtask

   // Drops or restores one enable condition
   task automatic lose(input int i, input logic on);
      case (i)
         0: env.ldo_good = !on;
         1: env.thermal_shutdown = on;
         2: env.temp_fault = on;
         3: env.adapter_path_fet = !on;
         4: env.adapter_overvoltage = on;
         5: env.adapter_undervoltage = on;
         default: begin
            env.sense_above_supply = on;
            env.supply_above_sense = !on;
         end
      endcase
   endtask

   // Each status change while not muted is matched against the oldest note
   always @(negedge sys_clk_i) begin
      if (word !== prev && !mute) begin
         exp_v = (q.size() != 0) ? q.pop_front() : 14'h3FFF;
         check("status", {2'h0, word, tgt}, {2'h0, exp_v});
      end
      prev = word;
   end

   // Cuts a hang short
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         end_of_test();
      end
   end

   // ------------
   // Scenarios
   // ------------
   initial begin
      env = '0;
      env.sense_above_supply = 1'b1;
      void'($urandom(32'h122D));
      code = 8'h50 + 8'($urandom_range(8'hAF));
      idle(12);
      rst_i = 1'b0;
      check("reset", {3'h0, slp, refe, soe_n, sout, chg, tgt}, 16'h1400);
      // Wake with the setpoint between thresholds
      note(6'h10, 8'h00);
      env.sense_above_supply = 1'b0;
      env.supply_above_sense = 1'b1;
      env.ldo_good = 1'b1;
      env.adapter_path_fet = 1'b1;
      settle(20);
      check("awake", {14'h0000, refe, soe_n}, 16'h0003);
      // Pre-charge, fast charge, termination
      note(6'h1C, code / 8'h0A);
      note(6'h18, code >> 3);
      note(6'h11, 8'h00);
      env.setpoint_above_high = 1'b1;
      idle(40);
      check("delay", {15'h0000, chg}, 16'h0000);
      settle(3000);
      // Recharge with termination off, then on
      mode = TIMER_PROG_GND;
      cmd = 2'h2;
      note(6'h10, 8'h00);
      note(6'h18, code >> 3);
      settle(20);
      cmd = 2'h0;
      idle(400);
      check("no term", {15'h0000, done}, 16'h0000);
      note(6'h11, 8'h00);
      mode = TIMER_PROG_REF;
      settle(20);
      // Loss and return of the LDO, thermal, temperature, path FET, adapter and sleep conditions
      cmd = 2'h2;
      note(6'h10, 8'h00);
      note(6'h18, code >> 3);
      settle(20);
      for (int i = 0; i < 7; i++) begin
         idle(80);
         lose(i, 1'b1);
         note((i < 4) ? 6'h10 : ((i < 6) ? 6'h00 : 6'h20), 8'h00);
         settle(20);
         lose(i, 1'b0);
         note(6'h18, code >> 3);
         settle(20);
      end
      // Setpoint hysteresis and toggle
      idle(80);
      env.setpoint_above_high = 1'b0;
      idle(20);
      check("hold on", {15'h0000, chg}, 16'h0001);
      note(6'h10, 8'h00);
      env.setpoint_below_low = 1'b1;
      settle(20);
      env.setpoint_below_low = 1'b0;
      idle(80);
      check("hold off", {15'h0000, chg}, 16'h0000);
      note(6'h18, code >> 3);
      env.setpoint_above_high = 1'b1;
      settle(100);
      // Lockout while charging, unobserved by the status matcher
      idle(80);
      mute = 1'b1;
      env.supply_uvlo = 1'b1;
      idle(10);
      check("lockout", {14'h0000, chg, fet}, 16'h0000);
      env.supply_uvlo = 1'b0;
      for (int i = 0; i < 200 && chg !== 1'b1; i++) idle(1);
      idle(80);
      mute = 1'b0;
      // Fast-charge timer expiry
      tmo = 40'h00_0000_001E;
      mode = TIMER_PROG_CAP;
      note(6'h12, 8'h00);
      settle(100);
      // Power-on cycle with a dead cell: pre-charge timeout
      note(6'h20, 8'h00);
      rst_i = 1'b1;
      cmd = 2'h3;
      idle(3);
      rst_i = 1'b0;
      note(6'h10, 8'h00);
      note(6'h1C, code / 8'h0A);
      note(6'h12, 8'h00);
      settle(400);
      end_of_test();
   end
endmodule // tb_charge_cycle_controller
